//--- core/duc_pkg.sv
// Constants, carrier types and state codes for the DAC update/status control block.
// Assumes a 100 MHz clock and a 7-bit byte-addressed I/O space with 16-bit data.
package duc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CHAN_SHIFT_TIME_NS = 2000;
  localparam int COEFF_WRITE_TIME_NS = 1000000;
  // Shortest busy time, so round up
  localparam int CHAN_SHIFT_CYCLES = (CHAN_SHIFT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COEFF_WRITE_CYCLES = (COEFF_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int NUM_CHAN = 16;
  localparam int COEFF_WORDS = 32;
  localparam int SHIFT_CNT_W = 8;
  localparam int COEFF_CNT_W = 17;

  localparam logic [6:0] OFS_CHAN_FIRST = 7'h00;
  localparam logic [6:0] OFS_CHAN_LAST = 7'h1E;
  localparam logic [6:0] OFS_TRANSPARENT = 7'h20;
  localparam logic [6:0] OFS_SIMULTANEOUS = 7'h22;
  localparam logic [6:0] OFS_TRIGGER = 7'h24;
  localparam logic [6:0] OFS_CHAN_BUSY = 7'h26;
  localparam logic [6:0] OFS_SOFT_RESET = 7'h28;
  localparam logic [6:0] OFS_COEFF_WEN = 7'h2A;
  localparam logic [6:0] OFS_COEFF_BUSY = 7'h2B;
  localparam logic [6:0] OFS_COEFF_FIRST = 7'h40;

  localparam int SOFT_RST_BIT = 7;
  localparam int COEFF_READY_BIT = 15;
  localparam logic [7:0] COEFF_WEN_KEY = 8'h03;
  localparam logic [15:0] SOFT_RESET_RST = 16'h0000;
  localparam logic [7:0] COEFF_WEN_RST = 8'h00;
  // Mid-scale code of the bipolar offset binary format is 0 V
  localparam logic [15:0] ZERO_VOLT_CODE = 16'h8000;

  typedef struct packed {
    logic sel;
    logic write;
    logic byte_acc;
    logic [6:0] addr;
    logic [15:0] wdata;
  } duc_req_s;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } duc_rsp_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_ACK = 3'b100
  } duc_bus_e;

  typedef logic [15:0] duc_word_t;
endpackage

//--- core/duc_top.sv
// Register side of a sixteen-channel double-buffered DAC: update modes, trigger,
// channel and coefficient busy status, soft reset and coefficient memory.
// Assumes a carrier bus master on the same clock that holds sel until ack.
`timescale 1ns/100ps
// Operation
// - Any trigger write fires the update, data ignored; reads return nothing.
// - Trigger copies all input latches into output latches at once.
// - Simultaneous mode holds new input data away from outputs until trigger.
// - Trigger write completes with one wait state.
// - Reset selects simultaneous mode and drives all outputs to zero volts.
// - Reset clears output latches only; input latches keep their contents.
// - Trigger write in transparent mode switches to simultaneous mode.
// - Write-status register bit n shows busy state of channel n.
// - Status bit drops on channel write, rises when serial transfer ends.
// - Writing one to control bit 7 sets all outputs to zero volts.
// - Control register resets to zero; byte and word accesses allowed.
// - Coefficient writes allowed only while write-enable bits 0 and 1 set.
// - Coefficient write in 40H..7FH stays in progress about one millisecond.
// - Coefficient status bit 15 low during write cycle, high after.
// - Coefficients readable at 40H..7FH by byte accesses only.
// - Signed 16-bit coefficient: high byte at even address, low at odd.
// - Coefficient read completes with one wait state.
// - Transparent mode updates a channel output as soon as it is written.
// - Sixteen channel registers 00H..1EH, each shifted out in about 2 us.
// - Writes to 20H/22H select transparent/simultaneous mode, one wait state.
module duc_top
  import duc_pkg::*;
#(
  parameter int COEFF_CYCLES = COEFF_WRITE_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  input wire duc_req_s bus_req,
  output duc_rsp_s bus_rsp,
  output duc_word_t [NUM_CHAN-1:0] dac_out,
  output logic transparent_mode
);
  localparam int A_SHIFT = CHAN_SHIFT_CYCLES;

  function automatic logic is_chan(input logic [6:0] a, input logic b);
    is_chan = (a <= OFS_CHAN_LAST) && !a[0] && !b;
  endfunction

  function automatic logic is_coeff(input logic [6:0] a);
    is_coeff = (a >= OFS_COEFF_FIRST);
  endfunction

  duc_bus_e state_q;
  logic take;
  logic wr;
  logic trig_wr;
  logic soft_rst;
  logic chan_wr;
  logic coeff_wr;
  logic [3:0] chan_idx;
  logic [4:0] coeff_idx;
  logic [15:0] rdata_q;
  logic transparent_q;
  logic [15:0] ctrl_q;
  logic [7:0] coeff_wen_q;
  logic [COEFF_CNT_W-1:0] coeff_cnt_q;
  logic coeff_ready;
  logic [NUM_CHAN-1:0] chan_ready;
  duc_word_t [NUM_CHAN-1:0] in_latch_q;
  duc_word_t [NUM_CHAN-1:0] out_latch_q;
  duc_word_t [COEFF_WORDS-1:0] coeff_mem_q;
  logic [3:0] last_chan_q;

  assign take = ce && bus_req.sel && (state_q == ST_IDLE);
  assign wr = take && bus_req.write;
  assign trig_wr = wr && (bus_req.addr == OFS_TRIGGER);
  assign chan_wr = wr && is_chan(bus_req.addr, bus_req.byte_acc);
  assign chan_idx = bus_req.addr[4:1];
  assign coeff_idx = bus_req.addr[5:1];
  assign soft_rst = wr && (bus_req.addr == OFS_SOFT_RESET)
                    && bus_req.wdata[SOFT_RST_BIT];
  // Only byte writes reach the memory, and only when unlocked and idle
  assign coeff_wr = wr && is_coeff(bus_req.addr) && bus_req.byte_acc && coeff_ready
                    && (coeff_wen_q[1:0] == COEFF_WEN_KEY[1:0]);
  assign coeff_ready = (coeff_cnt_q == '0);

  // Every access gets exactly one wait state before ack
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else if (ce) begin
      unique case (state_q)
        ST_IDLE: begin
          if (bus_req.sel) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: state_q <= ST_ACK;
        ST_ACK: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign bus_rsp = '{ack: (state_q == ST_ACK), rdata: rdata_q};

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_q <= '0;
    end else if (take) begin
      rdata_q <= '0;
      if (!bus_req.write) begin
        if (is_chan(bus_req.addr, bus_req.byte_acc)) begin
          rdata_q <= in_latch_q[chan_idx];
        end else if (bus_req.addr == OFS_CHAN_BUSY && !bus_req.byte_acc) begin
          rdata_q <= chan_ready;
        end else if (bus_req.addr == OFS_SOFT_RESET) begin
          rdata_q <= ctrl_q;
        end else if (bus_req.addr == OFS_COEFF_WEN) begin
          rdata_q <= bus_req.byte_acc ? {8'h00, coeff_wen_q}
                                      : {coeff_ready, 7'h00, coeff_wen_q};
        end else if (bus_req.addr == OFS_COEFF_BUSY && bus_req.byte_acc) begin
          rdata_q <= {8'h00, coeff_ready, 7'h00};
        end else if (is_coeff(bus_req.addr) && bus_req.byte_acc) begin
          // High byte at the even address
          rdata_q <= bus_req.addr[0] ? {8'h00, coeff_mem_q[coeff_idx][7:0]}
                                     : {8'h00, coeff_mem_q[coeff_idx][15:8]};
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      transparent_q <= 1'b0;
    end else if (wr) begin
      if (bus_req.addr == OFS_TRANSPARENT) begin
        transparent_q <= 1'b1;
      end else if (bus_req.addr == OFS_SIMULTANEOUS || trig_wr) begin
        transparent_q <= 1'b0;
      end
    end
  end

  assign transparent_mode = transparent_q;

  // Bit 7 clears itself once the output reset has been done
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_q <= SOFT_RESET_RST;
    end else if (ce) begin
      if (wr && bus_req.addr == OFS_SOFT_RESET) begin
        ctrl_q[7:0] <= bus_req.wdata[7:0];
        if (!bus_req.byte_acc) begin
          ctrl_q[15:8] <= bus_req.wdata[15:8];
        end
      end else if (ctrl_q[SOFT_RST_BIT]) begin
        ctrl_q[SOFT_RST_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      coeff_wen_q <= COEFF_WEN_RST;
    end else if (wr && bus_req.addr == OFS_COEFF_WEN) begin
      coeff_wen_q <= bus_req.wdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      coeff_cnt_q <= '0;
    end else if (ce) begin
      if (coeff_wr) begin
        coeff_cnt_q <= COEFF_CNT_W'(COEFF_CYCLES);
      end else if (!coeff_ready) begin
        coeff_cnt_q <= coeff_cnt_q - 1'b1;
      end
    end
  end

  // Nonvolatile contents: not touched by reset
  always_ff @(posedge clock) begin
    if (coeff_wr) begin
      if (bus_req.addr[0]) begin
        coeff_mem_q[coeff_idx][7:0] <= bus_req.wdata[7:0];
      end else begin
        coeff_mem_q[coeff_idx][15:8] <= bus_req.wdata[7:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      last_chan_q <= '0;
    end else if (chan_wr) begin
      last_chan_q <= chan_idx;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_chan
      logic [SHIFT_CNT_W-1:0] shift_cnt_q;
      logic hit;
      assign hit = chan_wr && (chan_idx == 4'(g));
      assign chan_ready[g] = (shift_cnt_q == '0);

      // Input latch keeps its contents across reset
      always_ff @(posedge clock) begin
        if (hit) begin
          in_latch_q[g] <= bus_req.wdata;
        end
      end

      always_ff @(posedge clock) begin
        if (sys_rst) begin
          shift_cnt_q <= '0;
        end else if (ce) begin
          if (hit) begin
            shift_cnt_q <= SHIFT_CNT_W'(CHAN_SHIFT_CYCLES);
          end else if (!chan_ready[g]) begin
            shift_cnt_q <= shift_cnt_q - 1'b1;
          end
        end
      end

      // Soft reset beats a trigger in the same cycle
      always_ff @(posedge clock) begin
        if (sys_rst || (ce && ctrl_q[SOFT_RST_BIT]) || soft_rst) begin
          out_latch_q[g] <= ZERO_VOLT_CODE;
        end else if (trig_wr) begin
          out_latch_q[g] <= in_latch_q[g];
        end else if (hit && transparent_q) begin
          out_latch_q[g] <= bus_req.wdata;
        end
      end
    end
  endgenerate

  assign dac_out = out_latch_q;

  property p_ack_one_wait;
    @(posedge clock) disable iff (sys_rst || !ce)
    take |-> !bus_rsp.ack ##1 !bus_rsp.ack ##1 bus_rsp.ack ##1 !bus_rsp.ack;
  endproperty
  a_ack_one_wait: assert property (p_ack_one_wait) else $error("ack timing wrong");

  property p_trig_copy;
    @(posedge clock) disable iff (sys_rst)
    (trig_wr && !soft_rst && !ctrl_q[SOFT_RST_BIT]) |=> (dac_out == $past(in_latch_q));
  endproperty
  a_trig_copy: assert property (p_trig_copy) else $error("trigger did not copy all");

  property p_trig_mode;
    @(posedge clock) disable iff (sys_rst)
    (trig_wr && transparent_q) |=> !transparent_mode;
  endproperty
  a_trig_mode: assert property (p_trig_mode) else $error("trigger kept transparent");

  property p_hold;
    @(posedge clock) disable iff (sys_rst)
    (!transparent_q && !trig_wr && !soft_rst && !ctrl_q[SOFT_RST_BIT]) |=> $stable(dac_out);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved without trigger");

  property p_busy_low;
    @(posedge clock) disable iff (sys_rst)
    chan_wr |=> !chan_ready[last_chan_q];
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("busy bit not low");

  property p_busy_len;
    @(posedge clock) disable iff (sys_rst || !ce)
    (chan_wr && chan_idx == 4'h0) |-> ##[A_SHIFT:A_SHIFT] !chan_ready[0] ##1 chan_ready[0];
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("channel busy wrong length");

  property p_soft;
    @(posedge clock) disable iff (sys_rst)
    soft_rst |=> (dac_out == {NUM_CHAN{ZERO_VOLT_CODE}});
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset left output");

  property p_trans;
    @(posedge clock) disable iff (sys_rst)
    (chan_wr && transparent_q && !trig_wr && !soft_rst && !ctrl_q[SOFT_RST_BIT])
      |=> (dac_out[last_chan_q] == $past(bus_req.wdata));
  endproperty
  a_trans: assert property (p_trans) else $error("transparent write not output");

  property p_coeff_gate;
    @(posedge clock) disable iff (sys_rst)
    $fell(coeff_ready) |-> ($past(coeff_wen_q[1:0]) == COEFF_WEN_KEY[1:0]);
  endproperty
  a_coeff_gate: assert property (p_coeff_gate) else $error("coeff write locked");

  property p_reset;
    @(posedge clock)
    $past(sys_rst) |-> (!transparent_mode && ctrl_q == SOFT_RESET_RST && (&chan_ready)
                        && dac_out == {NUM_CHAN{ZERO_VOLT_CODE}});
  endproperty
  a_reset: assert property (p_reset) else $error("bad state after reset");
endmodule

//--- testbench/duc_host.sv
// Host model of the carrier bus master, one task per I/O-space access.
// Assumes the block takes a request at an idle edge and pulses ack once.
`timescale 1ns/100ps
module duc_host
  import duc_pkg::*;
(
  input wire logic clock,
  output duc_req_s bus_req,
  input wire duc_rsp_s bus_rsp
);
  initial bus_req = '0;
  // Holds the request until ack is sampled high, then scrambles the
  // released lines so that stale values cannot pass for a real request
  task automatic access(input logic wr, input logic bt, input logic [6:0] a,
                        input duc_word_t d, output duc_word_t rd, output int n);
    n = 0;
    @(posedge clock);
    bus_req <= '{1'b1, wr, bt, a, d};
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (bus_rsp.ack !== 1'b1 && n < 20);
    @(posedge clock);
    rd = bus_rsp.rdata;
    bus_req <= '{1'b0, ~wr, ~bt, ~a, ~d};
  endtask
endmodule

//--- testbench/dac_update_status_control_tb_top.sv
// Self-checking bench for the DAC update and status control block.
// Assumes duc_host drives the bus; clock enable stays high except for one stretch in t_coeff.
`timescale 1ns/100ps
module dac_update_status_control_tb_top;
  import duc_pkg::*;
  localparam int COEFF_N = 20;
  logic clock;
  logic sys_rst;
  logic ce;
  duc_req_s bus_req;
  duc_rsp_s bus_rsp;
  duc_word_t [NUM_CHAN-1:0] dac_out;
  logic transparent_mode;
  duc_word_t rd;
  duc_word_t exp_out [NUM_CHAN];
  int n;
  int failures = 0;
  int check_count = 0;

  duc_top #(.COEFF_CYCLES(COEFF_N)) uut (.clock(clock), .sys_rst(sys_rst), .ce(ce),
    .bus_req(bus_req), .bus_rsp(bus_rsp), .dac_out(dac_out),
    .transparent_mode(transparent_mode));
  duc_host host (.clock(clock), .bus_req(bus_req), .bus_rsp(bus_rsp));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk_word(input string nm, input duc_word_t e, input duc_word_t g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_wait(input int e, input int g);
    check_count++;
    if (g != e) begin
      failures++;
      $display("mismatch ack cycles expected %0d seen %0d", e, g);
    end
  endtask

  // A missing ack counts as a failure even where no wait count is compared
  task automatic acc(input logic w, input logic bt, input logic [6:0] a, input duc_word_t d);
    host.access(w, bt, a, d, rd, n);
    if (n >= 20) begin
      failures++;
      $display("mismatch ack expected 1 seen 0");
    end
  endtask

  task automatic wr(input logic [6:0] a, input duc_word_t d, input logic bt = 1'b0);
    acc(1'b1, bt, a, d);
  endtask

  task automatic rdr(input logic [6:0] a, input logic bt = 1'b0);
    acc(1'b0, bt, a, 16'h0000);
  endtask

  task automatic chk_outs();
    for (int i = 0; i < NUM_CHAN; i++) chk_word("dac_out", exp_out[i], dac_out[i]);
  endtask

  task automatic set_outs(input logic zero);
    for (int i = 0; i < NUM_CHAN; i++) begin
      exp_out[i] = zero ? ZERO_VOLT_CODE : 16'h1357 + duc_word_t'(i) * 16'h0F0F;
    end
  endtask

  task automatic t_reset();
    set_outs(1'b1);
    chk_outs();
    chk_word("mode", 16'h0000, {15'h0000, transparent_mode});
    rdr(OFS_CHAN_BUSY);
    chk_word("chan busy", 16'hFFFF, rd);
    rdr(OFS_SOFT_RESET);
    chk_word("control", SOFT_RESET_RST, rd);
  endtask

  task automatic t_simul();
    set_outs(1'b0);
    for (int i = 0; i < NUM_CHAN; i++) wr(7'(2 * i), exp_out[i]);
    set_outs(1'b1);
    chk_outs();
    rdr(OFS_CHAN_BUSY);
    chk_word("chan busy", 16'h0000, rd);
    repeat (CHAN_SHIFT_CYCLES) @(posedge clock);
    rdr(OFS_CHAN_BUSY);
    chk_word("chan busy", 16'hFFFF, rd);
    wr(OFS_TRIGGER, 16'hA5C3);
    chk_wait(2, n);
    set_outs(1'b0);
    chk_outs();
    rdr(OFS_TRIGGER);
    chk_word("trigger read", 16'h0000, rd);
  endtask

  task automatic t_transp();
    wr(OFS_TRANSPARENT, 16'h0000);
    chk_wait(2, n);
    chk_word("mode", 16'h0001, {15'h0000, transparent_mode});
    wr(7'h06, 16'h4242);
    exp_out[3] = 16'h4242;
    chk_outs();
    wr(OFS_TRIGGER, 16'hFFFF);
    chk_word("mode", 16'h0000, {15'h0000, transparent_mode});
    chk_outs();
    wr(OFS_TRANSPARENT, 16'hFFFF);
    wr(OFS_SIMULTANEOUS, 16'h1234);
    chk_wait(2, n);
    chk_word("mode", 16'h0000, {15'h0000, transparent_mode});
  endtask

  task automatic t_soft();
    wr(OFS_SOFT_RESET, 16'h0080, 1'b1);
    set_outs(1'b1);
    chk_outs();
    rdr(OFS_SOFT_RESET, 1'b1);
    chk_word("control", 16'h0000, rd);
    wr(OFS_SOFT_RESET, 16'h5A55);
    wr(OFS_SOFT_RESET, 16'h0011, 1'b1);
    rdr(OFS_SOFT_RESET);
    chk_word("control", 16'h5A11, rd);
    // Second reset: output latches clear, input latches must survive
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    chk_outs();
    rdr(OFS_SOFT_RESET);
    chk_word("control", 16'h0000, rd);
    wr(OFS_TRIGGER, 16'h0000);
    set_outs(1'b0);
    exp_out[3] = 16'h4242;
    chk_outs();
  endtask

  task automatic t_coeff();
    wr(OFS_COEFF_WEN, 16'h0001);
    wr(OFS_COEFF_FIRST, 16'h005A, 1'b1);
    rdr(OFS_COEFF_BUSY, 1'b1);
    chk_word("coeff busy", 16'h0080, rd);
    wr(OFS_COEFF_WEN, 16'h0003);
    wr(OFS_COEFF_FIRST + 7'h3E, 16'h00C1, 1'b1);
    rdr(OFS_COEFF_BUSY, 1'b1);
    chk_word("coeff busy", 16'h0000, rd);
    repeat (COEFF_N) @(posedge clock);
    rdr(OFS_COEFF_BUSY, 1'b1);
    chk_word("coeff busy", 16'h0080, rd);
    wr(OFS_COEFF_FIRST + 7'h3F, 16'h0023, 1'b1);
    // Clock enable low must freeze the busy count, so the write is still running
    ce <= 1'b0;
    repeat (COEFF_N) @(posedge clock);
    ce <= 1'b1;
    rdr(OFS_COEFF_BUSY, 1'b1);
    chk_word("coeff busy frozen", 16'h0000, rd);
    repeat (COEFF_N) @(posedge clock);
    rdr(OFS_COEFF_FIRST + 7'h3E, 1'b1);
    chk_wait(2, n);
    chk_word("coeff msb", 16'h00C1, rd);
    rdr(OFS_COEFF_FIRST + 7'h3F, 1'b1);
    chk_word("coeff lsb", 16'h0023, rd);
    rdr(OFS_COEFF_FIRST + 7'h3E);
    chk_word("coeff word read", 16'h0000, rd);
  endtask

  task automatic results();
    if (failures == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    ce = 1'b1;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_simul();
    t_transp();
    t_soft();
    t_coeff();
    results();
  end

  // About 460 cycles are needed; this cuts a hang short
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    results();
  end
endmodule
